// [rtl/fdi_drive_if.sv]
// floppy drive host interface: selection, index, stepping, write gate and data
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
// Function
// - ignore host and disable functions until initialization completes, shown by track zero; head select still drives lower_head before it.
// - select only when the select line matching the address jumper is asserted.
// - always-selected jumper with no address jumper makes the drive permanently selected.
// - indicator option lights the front panel indicator whenever selected.
// - lock option locks door while selected and in-use true; deselect needs reselect.
// - sector/index output asserted 4 ms per passing hole, leading edge is reference.
// - move positioner one track per step pulse in the direction input's sense.
// - step period 6 ms or more is conventional, 3 to 5 ms is burst.
// - seek-complete option drives ready when head in position; drive adds 12 ms after conventional steps.
// - in burst mode direction sampled at first pulse applies to whole burst.
// - after a burst positioning completes within count times 6 ms plus 15 ms.
// - accept and count bursts of up to 256 step pulses.
// - head select high picks lower head, low picks upper head.
// - read channel off and steps ignored during write gate and trim erase.
// - trim erase on 425 us after gate asserts, off 950 us after release.
// - reverse write current on each falling edge of write data.
// - writing enabled only with gate true, no step in progress, not protected.
// - read data held invalid until 1100 us after write gate deasserts.
module fdi_drive_if #(
   parameter int SECT_CYCLES   = fdi_pkg::SECT_CYC,
   parameter int CONV_CYCLES   = fdi_pkg::CONV_CYC,
   parameter int BURST_CYCLES  = fdi_pkg::BURST_MAX_CYC,
   parameter int SETTLE_CYCLES = fdi_pkg::SETTLE_CYC,
   parameter int SEEKC_CYCLES  = fdi_pkg::SEEKCPL_CYC,
   parameter int TRIM_ON_CYCLES  = fdi_pkg::TRIM_ON_CYC,
   parameter int TRIM_OFF_CYCLES = fdi_pkg::TRIM_OFF_CYC,
   parameter int READ_CYCLES   = fdi_pkg::READ_VALID_CYC
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // host pins, active high inside the block
   input  wire logic [3:0]  unit_select_line,
   input  wire logic        in_use,
   input  wire logic        step_pulse,
   input  wire logic        step_direction,
   input  wire logic        head_side_select,
   input  wire logic        write_gate,
   input  wire logic        write_data_pulse,
   // drive sensors
   input  wire logic        hole_sensed,
   input  wire logic        read_flux,
   // host outputs
   output logic             track_zero_flag,
   output logic             sector_index_pulse,
   output logic             ready_out,
   output logic             read_data_pulse,
   // drive actuators
   output logic             selected_out,
   output logic             indicator_on,
   output logic             door_lock,
   output logic             step_move,
   output logic             step_outward,
   output logic             lower_head,
   output logic             write_enable,
   output logic             write_current,
   output logic             trim_erase
);
   localparam int CW = 32;
   if (SECT_CYCLES < 1 || CONV_CYCLES <= BURST_CYCLES || SETTLE_CYCLES < 1 ||
       TRIM_ON_CYCLES < 1 || TRIM_OFF_CYCLES < 1 || READ_CYCLES < TRIM_OFF_CYCLES) begin : g_bad
      $error("fdi_drive_if: timing parameters out of range");
   end

   // pin synchronisers, two flops each
   localparam int NS = 12;
   logic [NS-1:0] s1_reg;
   logic [NS-1:0] s2_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg <= '0;
         s2_reg <= '0;
      end else begin
         s1_reg <= {read_flux, unit_select_line, in_use, step_pulse, step_direction,
                    head_side_select, write_gate, write_data_pulse, hole_sensed};
         s2_reg <= s1_reg;
      end
   end
   wire       rf_s   = s2_reg[11];
   wire [3:0] ds_s   = s2_reg[10:7];
   wire       use_s  = s2_reg[6];
   wire       step_s = s2_reg[5];
   wire       dir_s  = s2_reg[4];
   wire       hs_s   = s2_reg[3];
   wire       wg_s   = s2_reg[2];
   wire       wd_s   = s2_reg[1];
   wire       hole_s = s2_reg[0];
   logic step_d_reg, wd_d_reg, hole_d_reg, wg_d_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_d_reg <= 1'b0;
         wd_d_reg   <= 1'b0;
         hole_d_reg <= 1'b0;
         wg_d_reg   <= 1'b0;
      end else begin
         step_d_reg <= step_s;
         wd_d_reg   <= wd_s;
         hole_d_reg <= hole_s;
         wg_d_reg   <= wg_s;
      end
   end

   // registers
   logic [31:0] ctrl_reg;
   wire         init_done = ctrl_reg[fdi_pkg::CTRL_INIT_DONE];
   wire [3:0]   addr_jmp  = ctrl_reg[fdi_pkg::CTRL_ADDR_LSB +: 4];
   wire         apb_wr    = psel && penable && pwrite;
   wire         hit_ctrl  = paddr == fdi_pkg::CTRL_ADDR;
   wire         hit_stat  = paddr == fdi_pkg::STATUS_ADDR;
   wire         hit_trk   = paddr == fdi_pkg::TRACK_ADDR;
   wire         hit_any   = hit_ctrl || hit_stat || hit_trk;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ctrl_reg <= fdi_pkg::CTRL_RESET;
      else if (apb_wr && hit_ctrl)
         ctrl_reg <= pwdata;
   end

   // selection
   wire addr_sel   = |(ds_s & addr_jmp);
   wire always_sel = ctrl_reg[fdi_pkg::CTRL_ALWAYS_SEL] && addr_jmp == 4'h0;
   logic lock_reg;
   // a locked drive stays selected until in-use drops and select is reasserted
   wire  sel_raw  = init_done && (addr_sel || always_sel);
   wire  sel      = sel_raw || lock_reg;
   logic sel_raw_d_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_reg      <= 1'b0;
         sel_raw_d_reg <= 1'b0;
      end else begin
         sel_raw_d_reg <= sel_raw;
         if (ctrl_reg[fdi_pkg::CTRL_LOCK] && sel && use_s)
            lock_reg <= 1'b1;
         else if (!use_s && sel_raw && !sel_raw_d_reg)
            lock_reg <= 1'b0;
      end
   end

   // sector/index pulse, timed from the hole's leading edge
   logic [CW-1:0] sect_cnt_reg;
   logic          sect_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sect_cnt_reg <= '0;
         sect_reg     <= 1'b0;
      end else if (hole_s && !hole_d_reg && init_done) begin
         sect_cnt_reg <= CW'(SECT_CYCLES - 1);
         sect_reg     <= 1'b1;
      end else if (sect_cnt_reg != '0) begin
         sect_cnt_reg <= sect_cnt_reg - 1'b1;
      end else begin
         sect_reg <= 1'b0;
      end
   end

   // write gate, trim erase and read recovery
   logic [CW-1:0] on_cnt_reg;
   logic [CW-1:0] off_cnt_reg;
   logic          trim_reg;
   logic          rd_inhibit_reg;
   wire           wg_act = wg_s && sel;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_cnt_reg     <= '0;
         off_cnt_reg    <= '0;
         trim_reg       <= 1'b0;
         rd_inhibit_reg <= 1'b0;
      end else if (wg_act) begin
         off_cnt_reg    <= '0;
         rd_inhibit_reg <= 1'b1;
         if (on_cnt_reg == CW'(TRIM_ON_CYCLES))
            trim_reg <= 1'b1;
         else
            on_cnt_reg <= on_cnt_reg + 1'b1;
      end else begin
         on_cnt_reg <= '0;
         if (rd_inhibit_reg) begin
            off_cnt_reg <= off_cnt_reg + 1'b1;
            if (off_cnt_reg == CW'(TRIM_OFF_CYCLES))
               trim_reg <= 1'b0;
            if (off_cnt_reg == CW'(READ_CYCLES))
               rd_inhibit_reg <= 1'b0;
         end
      end
   end
   // trim erase period ends no later than the read recovery time ends
   wire wr_busy = wg_act || rd_inhibit_reg;

   // stepping: mode from pulse period, burst count and time to position
   fdi_pkg::fdi_seek_type st_reg;
   logic [CW-1:0]  per_cnt_reg;
   logic [CW-1:0]  ttp_cnt_reg;
   logic [8:0]     burst_cnt_reg;
   logic           bdir_reg;
   logic           move_reg;
   logic           out_reg;
   logic [7:0]     track_reg;
   wire            step_edge = step_s && !step_d_reg && sel && !wr_busy;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg        <= fdi_pkg::SK_IDLE;
         per_cnt_reg   <= '0;
         ttp_cnt_reg   <= '0;
         burst_cnt_reg <= '0;
         bdir_reg      <= 1'b0;
         move_reg      <= 1'b0;
         out_reg       <= 1'b0;
         track_reg     <= '0;
      end else begin
         move_reg <= 1'b0;
         if (per_cnt_reg != '1)
            per_cnt_reg <= per_cnt_reg + 1'b1;
         if (step_edge) begin
            per_cnt_reg <= '0;
            move_reg    <= 1'b1;
         end
         case (st_reg)
            fdi_pkg::SK_IDLE: begin
               if (step_edge) begin
                  bdir_reg      <= dir_s;
                  out_reg       <= dir_s;
                  burst_cnt_reg <= 9'h001;
                  st_reg        <= fdi_pkg::SK_CONV;
               end
            end
            fdi_pkg::SK_CONV: begin
               if (step_edge) begin
                  // counter starts at zero on a step, so the period is count plus one
                  if (per_cnt_reg < CW'(CONV_CYCLES - 1)) begin
                     out_reg       <= bdir_reg;
                     burst_cnt_reg <= burst_cnt_reg + 1'b1;
                     st_reg        <= fdi_pkg::SK_BURST;
                  end else begin
                     bdir_reg      <= dir_s;
                     out_reg       <= dir_s;
                     burst_cnt_reg <= 9'h001;
                  end
               end else if (per_cnt_reg >= CW'(CONV_CYCLES)) begin
                  ttp_cnt_reg <= CW'(SEEKC_CYCLES);
                  st_reg      <= fdi_pkg::SK_SETTLE;
               end
            end
            fdi_pkg::SK_BURST: begin
               if (step_edge) begin
                  out_reg <= bdir_reg;
                  if (burst_cnt_reg != 9'(fdi_pkg::MAX_BURST))
                     burst_cnt_reg <= burst_cnt_reg + 1'b1;
               end else if (per_cnt_reg > CW'(BURST_CYCLES)) begin
                  ttp_cnt_reg <= CW'(SETTLE_CYCLES) +
                                 CW'(burst_cnt_reg) * CW'(CONV_CYCLES);
                  st_reg      <= fdi_pkg::SK_SETTLE;
               end
            end
            fdi_pkg::SK_SETTLE: begin
               // a conventional step may arrive while seek complete still settles
               if (step_edge) begin
                  bdir_reg      <= dir_s;
                  out_reg       <= dir_s;
                  burst_cnt_reg <= 9'h001;
                  st_reg        <= fdi_pkg::SK_CONV;
               end else if (ttp_cnt_reg != '0)
                  ttp_cnt_reg <= ttp_cnt_reg - 1'b1;
               else
                  st_reg <= fdi_pkg::SK_IDLE;
            end
            default: st_reg <= fdi_pkg::SK_IDLE;
         endcase
         // positioner stops at track zero; track count saturates at the top
         if (move_reg) begin
            if (out_reg && track_reg != 8'h00)
               track_reg <= track_reg - 1'b1;
            else if (!out_reg && track_reg != 8'(fdi_pkg::MAX_TRACK))
               track_reg <= track_reg + 1'b1;
         end
      end
   end
   wire stepping = st_reg != fdi_pkg::SK_IDLE;

   // write current toggles on each falling write data edge while writing is enabled
   logic wcur_reg;
   wire  wr_ok = wg_act && !stepping && !ctrl_reg[fdi_pkg::CTRL_WPROT];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         wcur_reg <= 1'b0;
      else if (wr_ok && !wd_s && wd_d_reg)
         wcur_reg <= !wcur_reg;
   end

   // registered outputs
   wire ready_n = ctrl_reg[fdi_pkg::CTRL_SEEK_CPL] ? (sel && !stepping) : sel;
   wire [31:0] status_w = {16'h0000, track_reg, 1'b0, trim_reg, wr_busy, stepping,
                           st_reg == fdi_pkg::SK_BURST, lock_reg, sel, init_done};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         track_zero_flag    <= 1'b0;
         sector_index_pulse <= 1'b0;
         ready_out          <= 1'b0;
         read_data_pulse    <= 1'b0;
         selected_out       <= 1'b0;
         indicator_on       <= 1'b0;
         door_lock          <= 1'b0;
         step_move          <= 1'b0;
         step_outward       <= 1'b0;
         lower_head         <= 1'b0;
         write_enable       <= 1'b0;
         write_current      <= 1'b0;
         trim_erase         <= 1'b0;
         prdata             <= '0;
         pready             <= 1'b0;
         pslverr            <= 1'b0;
      end else begin
         track_zero_flag    <= init_done && track_reg == 8'h00;
         sector_index_pulse <= sect_reg && sel;
         ready_out          <= ready_n;
         read_data_pulse    <= sel && !wr_busy && rf_s;
         selected_out       <= sel;
         indicator_on       <= ctrl_reg[fdi_pkg::CTRL_INDICATOR] && sel;
         door_lock          <= lock_reg;
         step_move          <= move_reg;
         step_outward       <= out_reg;
         lower_head         <= hs_s;
         write_enable       <= wr_ok;
         write_current      <= wcur_reg;
         trim_erase         <= trim_reg;
         pready             <= psel && !penable;
         pslverr            <= psel && !penable && !hit_any;
         if (psel && !penable && !pwrite) begin
            if (hit_ctrl)
               prdata <= ctrl_reg;
            else if (hit_stat)
               prdata <= status_w;
            else if (hit_trk)
               prdata <= {24'h000000, track_reg};
            else
               prdata <= '0;
         end
      end
   end
endmodule // fdi_drive_if

// [rtl/fdi_pkg.sv]
// constants, register map and types of the floppy drive host interface block
package fdi_pkg;
   // register byte addresses
   localparam logic [7:0] CTRL_ADDR   = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam logic [7:0] TRACK_ADDR  = 8'h08;
   // control register fields
   localparam int CTRL_ALWAYS_SEL = 0;
   localparam int CTRL_INDICATOR  = 1;
   localparam int CTRL_LOCK       = 2;
   localparam int CTRL_SEEK_CPL   = 3;
   localparam int CTRL_INIT_DONE  = 4;
   localparam int CTRL_WPROT      = 5;
   localparam int CTRL_ADDR_LSB   = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // timing, clock 20 MHz
   localparam int CLK_KHZ        = 20000;
   localparam int SECT_MS        = 4;
   localparam int CONV_MS        = 6;
   localparam int BURST_MAX_MS   = 5;
   localparam int SETTLE_MS      = 15;
   localparam int SEEKCPL_MS     = 12;
   localparam int TRIM_ON_US     = 425;
   localparam int TRIM_OFF_US    = 950;
   localparam int READ_VALID_US  = 1100;
   localparam int MS_CYC         = CLK_KHZ;
   localparam int US_CYC         = CLK_KHZ / 1000;
   localparam int SECT_CYC       = SECT_MS * MS_CYC;
   localparam int CONV_CYC       = CONV_MS * MS_CYC;
   localparam int BURST_MAX_CYC  = BURST_MAX_MS * MS_CYC;
   localparam int SETTLE_CYC     = SETTLE_MS * MS_CYC;
   localparam int SEEKCPL_CYC    = SEEKCPL_MS * MS_CYC;
   localparam int TRIM_ON_CYC    = TRIM_ON_US * US_CYC;
   localparam int TRIM_OFF_CYC   = TRIM_OFF_US * US_CYC;
   localparam int READ_VALID_CYC = READ_VALID_US * US_CYC;
   localparam int MAX_BURST      = 256;
   localparam int MAX_TRACK      = 255;
   typedef enum logic [3:0] {
      SK_IDLE   = 4'b0001,
      SK_CONV   = 4'b0010,
      SK_BURST  = 4'b0100,
      SK_SETTLE = 4'b1000
   } fdi_seek_type;
endpackage

// [verif/fdi_drive_if_sva.sv]
// port-level assertions for the floppy drive host interface
`timescale 1ns/1ps
module fdi_drive_if_sva #(
   parameter int SECT_CYCLES     = 20,
   parameter int TRIM_ON_CYCLES  = 5,
   parameter int TRIM_OFF_CYCLES = 10,
   parameter int READ_CYCLES     = 12
) (
   // clock, reset and bus handshake
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   // host pins
   input wire logic head_side_select,
   input wire logic write_gate,
   // outputs
   input wire logic sector_index_pulse,
   input wire logic read_data_pulse,
   input wire logic selected_out,
   input wire logic indicator_on,
   input wire logic door_lock,
   input wire logic step_move,
   input wire logic lower_head,
   input wire logic write_enable,
   input wire logic write_current,
   input wire logic trim_erase
);
   logic [15:0] hi_cnt;
   logic [15:0] lo_cnt;
   logic [15:0] sp_cnt;
   // gate-low count starts saturated so reset does not look like a fresh write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_cnt <= 16'h0;
         lo_cnt <= 16'hffff;
         sp_cnt <= 16'h0;
      end else begin
         hi_cnt <= write_gate ? hi_cnt + 16'h1 : 16'h0;
         lo_cnt <= write_gate ? 16'h0 : (lo_cnt == 16'hffff ? lo_cnt : lo_cnt + 16'h1);
         sp_cnt <= sector_index_pulse ? sp_cnt + 16'h1 : 16'h0;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_apb_answer: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_sector_width: assert property ($fell(sector_index_pulse) |->
      sp_cnt >= SECT_CYCLES && sp_cnt <= SECT_CYCLES + SECT_CYCLES / 4)
      else $error("sector pulse width wrong");
   a_indicator_sel: assert property (!selected_out && !$past(selected_out) |-> !indicator_on)
      else $error("indicator lit while idle");
   a_lock_sel: assert property ($rose(door_lock) |-> selected_out || $past(selected_out))
      else $error("door locked unselected");
   a_head_follow: assert property ($changed(head_side_select) ##1
      $stable(head_side_select) [*4] |-> lower_head == head_side_select)
      else $error("head select not followed");
   a_gate_write: assert property (lo_cnt > 16'h4 |-> !write_enable)
      else $error("write enabled without gate");
   a_write_nostep: assert property (write_enable |-> !step_move)
      else $error("write during step");
   a_step_in_write: assert property (hi_cnt > 16'h4 |-> !step_move)
      else $error("step taken during write");
   a_trim_on: assert property ($rose(trim_erase) |->
      hi_cnt >= TRIM_ON_CYCLES && hi_cnt <= TRIM_ON_CYCLES + 5)
      else $error("trim erase late or early on");
   a_trim_off: assert property ($fell(trim_erase) |->
      lo_cnt >= TRIM_OFF_CYCLES && lo_cnt <= TRIM_OFF_CYCLES + 5)
      else $error("trim erase late or early off");
   a_read_quiet: assert property (hi_cnt > 16'h4 || (hi_cnt == 16'h0 &&
      lo_cnt < READ_CYCLES) |-> !read_data_pulse)
      else $error("read data during inhibit");
   a_flux_write: assert property ($changed(write_current) |->
      write_enable || $past(write_enable))
      else $error("write current moved idle");
endmodule // fdi_drive_if_sva
bind fdi_drive_if fdi_drive_if_sva #(.SECT_CYCLES(SECT_CYCLES), .TRIM_ON_CYCLES(TRIM_ON_CYCLES),
   .TRIM_OFF_CYCLES(TRIM_OFF_CYCLES), .READ_CYCLES(READ_CYCLES)) u_sva (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .head_side_select(head_side_select), .write_gate(write_gate),
   .sector_index_pulse(sector_index_pulse), .read_data_pulse(read_data_pulse),
   .selected_out(selected_out), .indicator_on(indicator_on), .door_lock(door_lock),
   .step_move(step_move), .lower_head(lower_head), .write_enable(write_enable),
   .write_current(write_current), .trim_erase(trim_erase));

// [verif/fdi_drive_if_tb.sv]
// self-checking bench for the floppy drive host interface
`timescale 1ns/1ps
module fdi_drive_if_tb;
   localparam int SECT = 20;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, wc;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0]  unit_select_line;
   logic        in_use, head_side_select, hole_sensed, read_flux;
   logic        step_pulse, step_direction, write_gate, write_data_pulse;
   logic        track_zero_flag, sector_index_pulse, ready_out, read_data_pulse;
   logic        selected_out, indicator_on, door_lock, step_move, step_outward;
   logic        lower_head, write_enable, write_current, trim_erase;
   int          num_errors, checks_done, cycles, moves, m0;
   // trim and read recovery keep their real timing so those counters run in full
   fdi_drive_if #(.SECT_CYCLES(SECT), .CONV_CYCLES(60), .BURST_CYCLES(40),
      .SETTLE_CYCLES(30), .SEEKC_CYCLES(20)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .unit_select_line(unit_select_line),
      .in_use(in_use), .step_pulse(step_pulse), .step_direction(step_direction),
      .head_side_select(head_side_select), .write_gate(write_gate),
      .write_data_pulse(write_data_pulse), .hole_sensed(hole_sensed),
      .read_flux(read_flux), .track_zero_flag(track_zero_flag),
      .sector_index_pulse(sector_index_pulse), .ready_out(ready_out),
      .read_data_pulse(read_data_pulse), .selected_out(selected_out),
      .indicator_on(indicator_on), .door_lock(door_lock), .step_move(step_move),
      .step_outward(step_outward), .lower_head(lower_head),
      .write_enable(write_enable), .write_current(write_current),
      .trim_erase(trim_erase));
   fdi_host_model host (.pclk(pclk), .step_pulse(step_pulse),
      .step_direction(step_direction), .write_gate(write_gate),
      .write_data_pulse(write_data_pulse));
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task automatic test_done;
      if (num_errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wait_c(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // request held from setup until ready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) begin
         @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask
   task automatic lines(input logic [3:0] v);
      unit_select_line <= v;
      wait_c(6);
   endtask
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (step_move === 1'h1) moves <= moves + 1;
      if (cycles == 40000) begin
         num_errors = num_errors + 1;
         test_done;
      end
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {unit_select_line, in_use, head_side_select, hole_sensed, read_flux} = '0;
      presetn = 1'h0;
      wait_c(12);
      presetn <= 1'h1;
      wait_c(1);
      apb(1'h0, fdi_pkg::CTRL_ADDR, 32'h0);
      chk("ctrl reset", fdi_pkg::CTRL_RESET, q);
      apb(1'h0, 8'h0c, 32'h0);
      chk("unmapped error", 32'h1, e);
      chk("unmapped data", 32'h0, q);
      lines(4'h2);
      chk("selected before init", 32'h0, selected_out);
      apb(1'h1, fdi_pkg::CTRL_ADDR, 32'h11);
      lines(4'h0);
      chk("always selected", 32'h1, selected_out);
      apb(1'h1, fdi_pkg::CTRL_ADDR, 32'h21e);
      lines(4'h1);
      chk("wrong line", 32'h0, selected_out);
      lines(4'h2);
      chk("matching line", 32'h1, selected_out);
      chk("indicator", 32'h1, indicator_on);
      chk("track zero", 32'h1, track_zero_flag);
      in_use <= 1'h1;
      wait_c(6);
      lines(4'h0);
      chk("door locked", 32'h1, door_lock);
      chk("held selected", 32'h1, selected_out);
      in_use <= 1'h0;
      lines(4'h2);
      lines(4'h0);
      chk("released", 32'h0, selected_out);
      lines(4'h2);
      hole_sensed <= 1'h1;
      wait_c(2);
      hole_sensed <= 1'h0;
      wait_c(4);
      chk("sector pulse on", 32'h1, sector_index_pulse);
      wait_c(SECT + 6);
      chk("sector pulse off", 32'h0, sector_index_pulse);
      head_side_select <= 1'h1;
      wait_c(5);
      chk("lower head", 32'h1, lower_head);
      head_side_select <= 1'h0;
      wait_c(5);
      chk("upper head", 32'h0, lower_head);
      m0 = moves;
      host.steps(3, 70, 1'h0, 1'h0);
      wait_c(100);
      chk("conv moves", 32'h3, moves - m0);
      apb(1'h0, fdi_pkg::TRACK_ADDR, 32'h0);
      chk("conv track", 32'h3, q);
      chk("seek complete", 32'h1, ready_out);
      m0 = moves;
      host.steps(4, 30, 1'h0, 1'h1);
      wait_c(2);
      chk("burst busy", 32'h0, ready_out);
      wait_c(340);
      chk("burst moves", 32'h4, moves - m0);
      chk("burst inward", 32'h0, step_outward);
      apb(1'h0, fdi_pkg::TRACK_ADDR, 32'h0);
      chk("burst track", 32'h7, q);
      chk("burst ready", 32'h1, ready_out);
      m0 = moves;
      wc = write_current;
      // gate long enough for trim erase; odd pulse count leaves the current inverted
      fork
         host.frame(541);
         begin
            wait_c(20);
            chk("write enable", 32'h1, write_enable);
            read_flux <= 1'h1;
            host.steps(1, 10, 1'h1, 1'h0);
            chk("read off in write", 32'h0, read_data_pulse);
         end
      join
      wait_c(6);
      chk("step ignored", 32'h0, moves - m0);
      chk("flux reversals", {31'h0, ~wc}, write_current);
      chk("trim trailing", 32'h1, trim_erase);
      chk("read off in recovery", 32'h0, read_data_pulse);
      wait_c(fdi_pkg::READ_VALID_CYC + 10);
      read_flux <= 1'h1;
      wait_c(2);
      chk("trim off", 32'h0, trim_erase);
      chk("read after write", 32'h1, read_data_pulse);
      read_flux <= 1'h0;
      apb(1'h1, fdi_pkg::CTRL_ADDR, 32'h23e);
      fork
         host.frame(1);
         begin
            wait_c(20);
            chk("protected", 32'h0, write_enable);
         end
      join
      wait_c(30);
      test_done;
   end
endmodule // fdi_drive_if_tb

// [verif/fdi_host_model.sv]
// host controller model: step trains and write frames
`timescale 1ns/1ps
module fdi_host_model (
   // clock
   input wire logic pclk,
   // host pins toward the drive
   output logic     step_pulse,
   output logic     step_direction,
   output logic     write_gate,
   output logic     write_data_pulse
);
   initial begin
      step_pulse = 1'b0;
      step_direction = 1'b0;
      write_gate = 1'b0;
      write_data_pulse = 1'b0;
   end
   // gap is the full step period in cycles; flip turns direction after the first
   task automatic steps(input int n, input int gap, input logic dir, input logic flip);
      for (int i = 0; i < n; i++) begin
         step_direction <= (i > 0 && flip) ? !dir : dir;
         repeat (2) @(posedge pclk);
         step_pulse <= 1'b1;
         repeat (4) @(posedge pclk);
         step_pulse <= 1'b0;
         repeat (gap - 6) @(posedge pclk);
      end
   endtask
   task automatic frame(input int n);
      write_gate <= 1'b1;
      repeat (8) @(posedge pclk);
      for (int i = 0; i < n; i++) begin
         write_data_pulse <= 1'b1;
         repeat (6) @(posedge pclk);
         write_data_pulse <= 1'b0;
         repeat (10) @(posedge pclk);
      end
      write_gate <= 1'b0;
   endtask
endmodule // fdi_host_model
